// >>> verilog/mlr_exec.sv
/*
  execute logic for move-file, store-accumulator, load-literal, no-op,
  prescaler configuration load and return-with-literal.
  assumes the file space answers file_rdata combinationally for
  file_addr, and that stack_top holds the return address.
*/
`timescale 1ns/100ps
module mlr_exec (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        instr_valid,
  input  wire logic [11:0] instr,
  input  wire logic [7:0]  file_rdata,
  input  wire logic [9:0]  stack_top_entry,
  output logic [4:0]       file_addr,
  output logic             file_we,
  output logic [7:0]       file_wdata,
  output logic [7:0]       acc_r,
  output logic             zero_r,
  output logic             zero_we,
  output logic [7:0]       option_cfg_r,
  output logic             pc_load,
  output logic [9:0]       pc_load_val,
  output logic             busy,
  output logic             instr_ready
);
  // phase of the execute stage: run, or the stall after a return
  typedef enum logic {
    PH_RUN   = 1'b0,
    PH_STALL = 1'b1
  } mlr_phase_t;

  logic [1:0] rst_sync_r;
  logic       rst_n;
  logic       is_move;
  logic       is_store;
  logic       is_lit;
  logic       is_ret;
  logic       is_nop;
  logic       is_cfg;
  mlr_phase_t phase_r;
  mlr_phase_t phase_nxt;
  logic       go;
  logic [7:0] move_val;

  // zero test shared by the flag logic and its check
  function automatic logic is_zero_val(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  // two-stage reset release
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  mlr_decode u_dec (
    .instr    (instr),
    .is_move  (is_move),
    .is_store (is_store),
    .is_lit   (is_lit),
    .is_ret   (is_ret),
    .is_nop   (is_nop),
    .is_cfg   (is_cfg)
  );

  // one instruction per cycle except the return's second cycle
  assign instr_ready = (phase_r == PH_RUN);            // [RULE_04]
  assign busy        = (phase_r == PH_STALL);          // [RULE_06]
  assign go          = instr_valid && (phase_r == PH_RUN);
  assign move_val    = file_rdata;                     // [RULE_01]

  // file port: address field, write for store or move back
  always_comb begin
    file_addr  = instr[4:0];
    file_we    = go && (is_store ||
                 (is_move && instr[mlr_pkg::DEST_BIT])); // [RULE_02] [RULE_05]
    file_wdata = is_store ? acc_r : move_val;
    zero_we    = go && is_move;                        // [RULE_03]
    pc_load    = go && is_ret;                         // [RULE_06]
    pc_load_val = stack_top_entry;
  end

  // accumulator updates
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= mlr_pkg::ACC_RST;
    end else if (go && is_move && !instr[mlr_pkg::DEST_BIT]) begin
      acc_r <= move_val;                               // [RULE_02]
    end else if (go && (is_lit || is_ret)) begin
      acc_r <= instr[7:0];                             // [RULE_06] [RULE_07]
    end
  end

  // zero flag, only move-file touches it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      zero_r <= mlr_pkg::ZERO_RST;
    end else if (go && is_move) begin
      zero_r <= is_zero_val(move_val);                 // [RULE_03]
    end
  end

  // prescaler configuration register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      option_cfg_r <= mlr_pkg::CFG_RST;
    end else if (go && is_cfg) begin
      option_cfg_r <= acc_r;                           // [RULE_07]
    end
  end

  // phase machine: a taken return buys one stall cycle for the refetch
  always_comb begin
    case (phase_r)
      PH_RUN: begin
        phase_nxt = (go && is_ret) ? PH_STALL : PH_RUN;  // [RULE_06]
      end
      PH_STALL: begin
        phase_nxt = PH_RUN;  // word offered here is dropped
      end
      default: begin
        phase_nxt = PH_RUN;
      end
    endcase
  end

  // phase register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= PH_RUN;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // move_file_op sets the zero flag from the moved value
  move_zero_a: assert property ( // [RULE_03]
    @(posedge clk_sys) disable iff (!rst_n)
    go && is_move |=> zero_r == is_zero_val($past(move_val)))
    else $error("zero flag wrong after move");

  // move with destination clear lands in the accumulator
  move_dest_a: assert property ( // [RULE_02]
    @(posedge clk_sys) disable iff (!rst_n)
    go && is_move && !instr[mlr_pkg::DEST_BIT] |=>
    acc_r == $past(move_val))
    else $error("move to accumulator failed");

  // move with destination set writes the same value back
  move_back_a: assert property ( // [RULE_01] [RULE_02]
    @(posedge clk_sys) disable iff (!rst_n)
    go && is_move && instr[mlr_pkg::DEST_BIT] |->
    file_we && file_wdata == file_rdata)
    else $error("move write back failed");

  // store_accumulator_op drives the file port, no flag strobe
  store_acc_a: assert property ( // [RULE_05]
    @(posedge clk_sys) disable iff (!rst_n)
    go && is_store |-> file_we && file_wdata == acc_r && !zero_we)
    else $error("store accumulator failed");

  // store leaves the accumulator and the zero flag alone
  store_flag_a: assert property ( // [RULE_05]
    @(posedge clk_sys) disable iff (!rst_n)
    go && is_store |=> $stable(zero_r) && $stable(acc_r))
    else $error("store changed flag or accumulator");

  // return_with_literal_op: one dead cycle, then ready again
  ret_two_a: assert property ( // [RULE_06]
    @(posedge clk_sys) disable iff (!rst_n)
    go && is_ret |=> !instr_ready ##1 instr_ready)
    else $error("return not two cycles");

  // return loads the pc at once and the literal on the next edge
  ret_lit_a: assert property ( // [RULE_06]
    @(posedge clk_sys) disable iff (!rst_n)
    go && is_ret |-> pc_load ##1 acc_r == $past(instr[7:0]))
    else $error("return literal wrong");

  // return touches neither the file nor the zero flag
  ret_flag_a: assert property ( // [RULE_06]
    @(posedge clk_sys) disable iff (!rst_n)
    go && is_ret |-> (!zero_we && !file_we) ##1 $stable(zero_r))
    else $error("return changed file or flag");

  // a word offered in the stall cycle has no effect
  stall_quiet_a: assert property ( // [RULE_06]
    @(posedge clk_sys) disable iff (!rst_n)
    busy |-> !file_we && !zero_we && !pc_load)
    else $error("word taken during stall");

  // every other op of the group leaves the stage ready
  single_cyc_a: assert property ( // [RULE_04]
    @(posedge clk_sys) disable iff (!rst_n)
    go && !is_ret |=> instr_ready)
    else $error("single cycle op stalled");

  // load_literal_op fills the accumulator, zero flag kept
  lit_keep_a: assert property ( // [RULE_07]
    @(posedge clk_sys) disable iff (!rst_n)
    go && is_lit |=> acc_r == $past(instr[7:0]) && $stable(zero_r))
    else $error("literal load wrong");

  // configuration load copies the accumulator
  cfg_load_a: assert property ( // [RULE_07]
    @(posedge clk_sys) disable iff (!rst_n)
    go && is_cfg |=> option_cfg_r == $past(acc_r))
    else $error("config load wrong");

  // configuration load writes nothing else
  cfg_quiet_a: assert property ( // [RULE_07]
    @(posedge clk_sys) disable iff (!rst_n)
    go && is_cfg |-> (!file_we && !zero_we) ##1 $stable(acc_r))
    else $error("config load disturbed other state");

  // configuration register moves only on its own load
  cfg_hold_a: assert property ( // [RULE_07]
    @(posedge clk_sys) disable iff (!rst_n)
    !(go && is_cfg) |=> $stable(option_cfg_r))
    else $error("config register changed without load");

  // no-op keeps accumulator and flag
  nop_still_a: assert property ( // [RULE_07]
    @(posedge clk_sys) disable iff (!rst_n)
    go && is_nop |=> $stable(acc_r) && $stable(zero_r))
    else $error("no-op changed state");

  // no-op raises no strobe
  nop_quiet_a: assert property ( // [RULE_07]
    @(posedge clk_sys) disable iff (!rst_n)
    go && is_nop |-> !file_we && !zero_we && !pc_load)
    else $error("no-op raised a strobe");
endmodule

// >>> verilog/mlr_pkg.sv
/*
  package for the move/literal/return execute group of an 8-bit core:
  opcode patterns, field positions, reset values, cycle counts.
  assumes a 12-bit instruction word presented once per instruction cycle.
*/
// Functional notes
// RULE_01 - move-file matched on upper six opcode bits
// RULE_02 - destination bit picks accumulator or file
// RULE_03 - move-file sets zero flag from value
// RULE_04 - these five run in one cycle
// RULE_05 - store-accumulator writes file, flags untouched
// RULE_06 - return loads literal, pc from stack top
// RULE_07 - literal load, no-op, prescaler config load
package mlr_pkg;
  localparam int          IW          = 12;
  localparam int          DW          = 8;
  localparam int          FW          = 5;
  localparam int          PW          = 10;
  localparam int          DEST_BIT    = 5;
  localparam logic [5:0]  OPC_MOVE    = 6'h08;  // 0010 00
  localparam logic [6:0]  OPC_STORE   = 7'h01;  // 0000 001
  localparam logic [3:0]  OPC_LIT     = 4'hc;   // 1100
  localparam logic [3:0]  OPC_RET     = 4'h8;   // 1000
  localparam logic [11:0] OPC_NOP     = 12'h000;
  localparam logic [11:0] OPC_CFG     = 12'h002;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic        ZERO_RST    = 1'b0;
  localparam logic [7:0]  CFG_RST     = 8'hff;
  localparam logic [1:0]  RET_CYCLES  = 2'h2;
endpackage

// >>> verilog/mlr_decode.sv
/*
  combinational opcode classifier for the execute group.
  assumes a stable instruction word from the fetch path.
*/
`timescale 1ns/100ps
module mlr_decode (
  input  wire logic [11:0] instr,
  output logic             is_move,
  output logic             is_store,
  output logic             is_lit,
  output logic             is_ret,
  output logic             is_nop,
  output logic             is_cfg
);
  // pattern matches on the fixed opcode bits
  always_comb begin
    is_move  = (instr[11:6] == mlr_pkg::OPC_MOVE);   // [RULE_01]
    is_store = (instr[11:5] == mlr_pkg::OPC_STORE);  // [RULE_05]
    is_lit   = (instr[11:8] == mlr_pkg::OPC_LIT);    // [RULE_07]
    is_ret   = (instr[11:8] == mlr_pkg::OPC_RET);    // [RULE_06]
    is_nop   = (instr == mlr_pkg::OPC_NOP);          // [RULE_07]
    is_cfg   = (instr == mlr_pkg::OPC_CFG);          // [RULE_07]
  end
endmodule

// >>> test/mlr_exec_tb.sv
/*
  self-checking bench for mlr_exec: random instruction stream, model check.
  assumes the design's assertions sit in its own files.
*/
`timescale 1ns/100ps
module mlr_exec_tb;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        instr_valid = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [7:0]  file_rdata = 8'h00;
  logic [9:0]  stack_top_entry = 10'h000;
  logic [4:0]  file_addr;
  logic        file_we, zero_r, zero_we, pc_load, busy, instr_ready;
  logic [7:0]  file_wdata, acc_r, option_cfg_r;
  logic [9:0]  pc_load_val;
  int          n_fail = 0;
  int          num_checks = 0;
  logic [15:0] r = 16'h514a;
  logic [7:0]  acc_m, opt_m;
  logic        zr_m;
  logic        vld;
  logic        wr;
  logic [11:0] ins;
  int          op;
  mlr_exec dut_u (.clk_sys(clk_sys), .nrst(nrst), .instr_valid(instr_valid),
    .instr(instr), .file_rdata(file_rdata), .stack_top_entry(stack_top_entry),
    .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
    .acc_r(acc_r), .zero_r(zero_r), .zero_we(zero_we),
    .option_cfg_r(option_cfg_r), .pc_load(pc_load), .pc_load_val(pc_load_val),
    .busy(busy), .instr_ready(instr_ready));
  // free-running 8 ns clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
  // reset, then random stream against the model
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    acc_m = 8'h00;
    opt_m = 8'hff;
    zr_m = 1'b0;
    chk("acc0", acc_r, acc_m);
    chk("opt0", option_cfg_r, opt_m);
    chk("zero0", zero_r, zr_m);
    chk("rdy0", instr_ready, 1'b1);
    for (int i = 0; i < 400; i++) begin
      r = lfsr(r);
      op = r[10:8];
      vld = r[12:11] != 2'h0;
      ins = op == 0 ? {6'h08, r[5], r[4:0]} : op == 1 ? {7'h01, r[4:0]} :
            op == 2 ? {4'hc, r[7:0]} : op == 3 ? {4'h8, r[7:0]} :
            op == 4 ? 12'h000 : op == 5 ? 12'h002 : {4'he, r[7:0]};
      instr = ins;
      instr_valid = vld;
      file_rdata = r[2] ? 8'h00 : r[15:8];
      stack_top_entry = {r[1:0], r[15:8]};
      wr = vld && (op == 1 || (op == 0 && ins[5]));
      #1;
      chk("addr", file_addr, ins[4:0]);
      chk("we", file_we, wr);
      if (wr && op == 1) chk("wdata", file_wdata, acc_m);
      if (wr && op == 0) chk("wback", file_wdata, file_rdata);
      chk("zwe", zero_we, vld && op == 0);
      chk("pcld", pc_load, vld && op == 3);
      if (op == 3) chk("pcval", pc_load_val, stack_top_entry);
      if (vld && op == 0) zr_m = file_rdata == 8'h00;
      if (vld && op == 0 && !ins[5]) acc_m = file_rdata;
      if (vld && (op == 2 || op == 3)) acc_m = ins[7:0];
      if (vld && op == 5) opt_m = acc_m;
      @(posedge clk_sys);
      #1;
      chk("acc", acc_r, acc_m);
      chk("zero", zero_r, zr_m);
      chk("opt", option_cfg_r, opt_m);
      chk("busy", busy, vld && op == 3);
      chk("rdy", instr_ready, !(vld && op == 3));
      if (vld && op == 3) begin
        instr = {4'h8, ~ins[7:0]};
        #1;
        chk("pcld2", pc_load, 1'b0);
        @(posedge clk_sys);
        #1;
        chk("stall", acc_r, acc_m);
        chk("busy2", busy, 1'b0);
      end
    end
    end_of_test();
  end
endmodule
